// ---- core/pls_pkg.sv ----
/*
  pls_pkg: constants, latch field positions and timing for the
  synthesizer digital core.
  assumes one 10 MHz clock and latches loaded only over the serial pins.
*/
// Summary of operation
// - shift one bit per serial clock, msb first
// - load strobe rise copies shift register out
// - two low bits pick latch, not stored
// - select 0 ref, 1 feedback, 2 function, 3 init
// - prescaler moduli 8/9, 16/17, 32/33, 64/65
// - main counter 13 bits, host writes 3..8191
// - swallow counter 6 bits, values 0..63
// - reference divider 14 bits, ratio 1..16383
// - feedback ratio is modulus times main plus swallow
// - two bit field sets antibacklash pulse width
// - three bit field picks monitor output source
// - lock after three good cycles, precision clear
// - lock after five good cycles, precision set
// - lock drops on error above 25 ns
// - reference latch field layout above divide value
// - feedback latch holds swallow, main, pump gain
// - detector compares reference and feedback edges
// - analog lock stays high with narrow low pulses
package pls_pkg;
  // ====================================================
  // serial word and latch select
  localparam int SR_W = 24;
  localparam int SEL_W = 2;
  localparam logic [1:0] SEL_REF = 2'h0;
  localparam logic [1:0] SEL_FB = 2'h1;
  localparam logic [1:0] SEL_FUNC = 2'h2;
  localparam logic [1:0] SEL_INIT = 2'h3;
  // ====================================================
  // reference divider latch
  localparam int REF_DIV_LSB = 2;
  localparam int REF_DIV_W = 14;
  localparam int ABP_LSB = 16;
  localparam int ABP_W = 2;
  localparam int LDP_BIT = 20;
  // ====================================================
  // feedback divider latch
  localparam int SWAL_LSB = 2;
  localparam int SWAL_W = 6;
  localparam int MAIN_LSB = 8;
  localparam int MAIN_W = 13;
  localparam int GAIN_BIT = 21;
  // ====================================================
  // function latch
  localparam int CRST_BIT = 2;
  localparam int PD1_BIT = 3;
  localparam int MUX_LSB = 4;
  localparam int MUX_W = 3;
  localparam int POL_BIT = 8;
  localparam int TRI_BIT = 9;
  localparam int PD2_BIT = 21;
  localparam int PRE_LSB = 22;
  localparam int PRE_W = 2;
  localparam logic [6:0] PRE_BASE = 7'h08;
  // ====================================================
  // monitor sources
  localparam logic [2:0] MUX_LOW = 3'h0;
  localparam logic [2:0] MUX_LOCK = 3'h1;
  localparam logic [2:0] MUX_FB = 3'h2;
  localparam logic [2:0] MUX_HIGH = 3'h3;
  localparam logic [2:0] MUX_REF = 3'h4;
  localparam logic [2:0] MUX_ALOCK = 3'h5;
  localparam logic [2:0] MUX_SDO = 3'h6;
  // ====================================================
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int LOCK_WIN_NS = 15;
  localparam int UNLOCK_NS = 25;
  localparam int LOCK_WIN_CYC = (LOCK_WIN_NS / CLK_PERIOD_NS < 1) ? 1 : LOCK_WIN_NS / CLK_PERIOD_NS;
  localparam int UNLOCK_RAW = (UNLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UNLOCK_CYC = (UNLOCK_RAW < 1) ? 1 : UNLOCK_RAW;
  localparam logic [2:0] LOCK_CNT_LO = 3'h3;
  localparam logic [2:0] LOCK_CNT_HI = 3'h5;
  localparam logic [2:0] ABP_BASE = 3'h1;

  function automatic logic [6:0] pre_mod(input logic [1:0] sel);
    return PRE_BASE << sel;
  endfunction : pre_mod
endpackage : pls_pkg

// ---- core/pls_pin_sync.sv ----
/*
  pls_pin_sync: three flop synchroniser per pin with agreement filter
  and a one cycle rise pulse.
  assumes pins are asynchronous to ref_clk_i.
*/
`timescale 1ns/1ps
module pls_pin_sync #(
  parameter int N = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [N-1:0] pin_i,
  output logic [N-1:0] level_o,
  output logic [N-1:0] rise_o
);
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] lvl;
    logic [N-1:0] rise;
  } pls_sync_t;

  pls_sync_t q;
  pls_sync_t d;

  // ====================================================
  // filter: a change counts only once stages two and three agree
  always_comb
  begin
    d = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 | q.s3));
    d.rise = d.lvl & ~q.lvl;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= d;
  end

  assign level_o = q.lvl;
  assign rise_o = q.rise;
endmodule : pls_pin_sync

// ---- core/pls_fb_div.sv ----
/*
  pls_fb_div: dual modulus prescaler with swallow and main counters.
  assumes rf_rise_i is a filtered one cycle pulse per rf edge.
*/
`timescale 1ns/1ps
module pls_fb_div (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic rf_rise_i,
  input wire logic [1:0] pre_sel_i,
  input wire logic [5:0] swallow_i,
  input wire logic [12:0] main_i,
  output logic fb_pulse_o
);
  typedef struct packed {
    logic [6:0] pc;
    logic [5:0] ac;
    logic [12:0] bc;
    logic pulse;
  } pls_fbd_t;

  pls_fbd_t q;
  pls_fbd_t d;
  logic [6:0] mod;

  // ====================================================
  // pulse swallowing: modulus p+1 until swallow count is met
  always_comb
  begin
    d = q;
    d.pulse = 1'b0;
    mod = pls_pkg::pre_mod(pre_sel_i) + {6'h00, q.ac < swallow_i};
    if (clr_i)
      d = '0;
    else if (rf_rise_i)
    begin
      if (7'(q.pc + 7'h01) >= mod)
      begin
        d.pc = 7'h00;
        if (q.ac < swallow_i)
          d.ac = 6'(q.ac + 6'h01);
        if (13'(q.bc + 13'h0001) >= main_i)
        begin
          d.bc = 13'h0000;
          d.ac = 6'h00;
          d.pulse = 1'b1;
        end
        else
          d.bc = 13'(q.bc + 13'h0001);
      end
      else
        d.pc = 7'(q.pc + 7'h01);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= d;
  end

  assign fb_pulse_o = q.pulse;

  // ====================================================
  // checks: count rf edges per output pulse while settings hold
  logic [19:0] span_q;
  logic clean_q;
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      span_q <= 20'h00000;
      clean_q <= 1'b0;
    end
    else
    begin
      if (q.pulse)
        span_q <= 20'h00000;
      else if (rf_rise_i)
        span_q <= 20'(span_q + 20'h00001);
      if (q.pulse)
        clean_q <= 1'b1;
      else if (clr_i || $changed(pre_sel_i) || $changed(swallow_i) || $changed(main_i))
        clean_q <= 1'b0;
    end
  end

  // a modulus change may leave the count out of range until the next rf edge
  chk_pre_range: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    clean_q && !$changed(pre_sel_i) && !$changed(swallow_i) |-> q.pc < mod)
    else $error("prescaler count beyond modulus");
  chk_fb_ratio: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (d.pulse && clean_q && !clr_i && main_i >= 13'h0003 && {7'h00, main_i} >= {14'h0000, swallow_i})
    |-> 20'(span_q + 20'h00001) ==
        20'(pls_pkg::pre_mod(pre_sel_i)) * 20'(main_i) + 20'(swallow_i))
    else $error("feedback ratio differs from modulus times main plus swallow");
endmodule : pls_fb_div

// ---- core/pls_core.sv ----
/*
  pls_core: digital section of the synthesizer: serial load, latches,
  reference and feedback dividers, phase detector, lock detect, monitor.
  assumes serial, reference and rf pins are asynchronous and slow
  against the 10 MHz ref_clk_i; rf edges here are prescaled-domain edges.
*/
`timescale 1ns/1ps
module pls_core (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic load_strobe_i,
  input wire logic ref_input_i,
  input wire logic rf_input_i,
  output logic pump_up_o,
  output logic pump_dn_o,
  output logic pump_hiz_o,
  output logic pump_gain_o,
  output logic power_down_o,
  output logic lock_detect_o,
  output logic monitor_output_o
);
  localparam int P_SCLK = 0;
  localparam int P_DATA = 1;
  localparam int P_LE = 2;
  localparam int P_REF = 3;
  localparam int P_RF = 4;
  localparam int NPIN = 5;

  typedef struct packed {
    logic [23:0] sr;
    logic [23:0] ref_l;
    logic [23:0] fb_l;
    logic [23:0] fn_l;
    logic init_clr;
    logic [13:0] r_cnt;
    logic ref_pulse;
    logic up;
    logic dn;
    logic [2:0] abp_cnt;
    logic [7:0] err_cnt;
    logic [2:0] good_cnt;
    logic lock;
    logic ref_tgl;
    logic fb_tgl;
    logic pump_up;
    logic pump_dn;
    logic pump_hiz;
    logic pump_gain;
    logic pwr_dn;
    logic mon;
  } pls_core_t;

  pls_core_t q;
  pls_core_t d;

  logic [NPIN-1:0] sy_lvl;
  logic [NPIN-1:0] sy_rise;
  logic fb_pulse;
  logic [13:0] r_div;
  logic [1:0] abp;
  logic lock_precision_sel;
  logic [2:0] need;
  logic [2:0] abp_len;
  logic [2:0] mux;
  logic pol;
  logic tri_st;
  logic pd;
  logic hold;
  logic eval;
  logic eval_bad;

  // ====================================================
  // pin synchronisers and feedback divider
  pls_pin_sync #(
    .N(NPIN)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pin_i({rf_input_i, ref_input_i, load_strobe_i, ser_data_i, ser_clk_i}),
    .level_o(sy_lvl),
    .rise_o(sy_rise)
  );

  pls_fb_div u_fb_div (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clr_i(hold),
    .rf_rise_i(sy_rise[P_RF]),
    .pre_sel_i(q.fn_l[pls_pkg::PRE_LSB +: pls_pkg::PRE_W]),
    .swallow_i(q.fb_l[pls_pkg::SWAL_LSB +: pls_pkg::SWAL_W]),
    .main_i(q.fb_l[pls_pkg::MAIN_LSB +: pls_pkg::MAIN_W]),
    .fb_pulse_o(fb_pulse)
  );

  // ====================================================
  // latch fields
  always_comb
  begin
    r_div = q.ref_l[pls_pkg::REF_DIV_LSB +: pls_pkg::REF_DIV_W];
    abp = q.ref_l[pls_pkg::ABP_LSB +: pls_pkg::ABP_W];
    lock_precision_sel = q.ref_l[pls_pkg::LDP_BIT];
    need = lock_precision_sel ? pls_pkg::LOCK_CNT_HI : pls_pkg::LOCK_CNT_LO;
    abp_len = {1'b0, abp} + pls_pkg::ABP_BASE;
    mux = q.fn_l[pls_pkg::MUX_LSB +: pls_pkg::MUX_W];
    pol = q.fn_l[pls_pkg::POL_BIT];
    tri_st = q.fn_l[pls_pkg::TRI_BIT];
    pd = q.fn_l[pls_pkg::PD1_BIT];
    // counter reset, power-down and an init load all park the counters
    hold = q.fn_l[pls_pkg::CRST_BIT] | pd | q.init_clr;
    eval = q.up & q.dn & (q.abp_cnt == abp_len);
    eval_bad = eval && (q.err_cnt >= 8'(pls_pkg::UNLOCK_CYC));
  end

  // ====================================================
  // next state
  always_comb
  begin
    d = q;
    d.init_clr = 1'b0;
    d.ref_pulse = 1'b0;

    // serial shift and load
    if (sy_rise[P_SCLK])
      d.sr = {q.sr[pls_pkg::SR_W-2:0], sy_lvl[P_DATA]};
    if (sy_rise[P_LE])
    begin
      case (q.sr[pls_pkg::SEL_W-1:0])
        pls_pkg::SEL_REF:
          d.ref_l = {q.sr[pls_pkg::SR_W-1:pls_pkg::SEL_W], 2'h0};
        pls_pkg::SEL_FB:
          d.fb_l = {q.sr[pls_pkg::SR_W-1:pls_pkg::SEL_W], 2'h0};
        pls_pkg::SEL_FUNC:
          d.fn_l = {q.sr[pls_pkg::SR_W-1:pls_pkg::SEL_W], 2'h0};
        pls_pkg::SEL_INIT:
        begin
          // init load writes the function latch and restarts the counters
          d.fn_l = {q.sr[pls_pkg::SR_W-1:pls_pkg::SEL_W], 2'h0};
          d.init_clr = 1'b1;
        end
        default:
          d.fn_l = q.fn_l;
      endcase
    end

    // reference divider: ratio 0 behaves as 1
    if (hold)
      d.r_cnt = 14'h0000;
    else if (sy_rise[P_REF])
    begin
      if (15'({1'b0, q.r_cnt} + 15'h0001) >= {1'b0, r_div})
      begin
        d.r_cnt = 14'h0000;
        d.ref_pulse = 1'b1;
      end
      else
        d.r_cnt = 14'(q.r_cnt + 14'h0001);
    end

    // phase frequency detector with antibacklash hold-off
    if (hold)
    begin
      d.up = 1'b0;
      d.dn = 1'b0;
      d.abp_cnt = 3'h0;
      d.err_cnt = 8'h00;
      d.good_cnt = 3'h0;
      d.lock = 1'b0;
    end
    else
    begin
      if (q.ref_pulse)
        d.up = 1'b1;
      if (fb_pulse)
        d.dn = 1'b1;
      if ((q.up ^ q.dn) && q.err_cnt != 8'hff)
        d.err_cnt = 8'(q.err_cnt + 8'h01);
      if (q.up & q.dn)
      begin
        // edges landing during the hold-off are dropped, as in a real pfd
        if (eval)
        begin
          d.up = 1'b0;
          d.dn = 1'b0;
          d.abp_cnt = 3'h0;
          d.err_cnt = 8'h00;
          if (q.err_cnt < 8'(pls_pkg::LOCK_WIN_CYC))
          begin
            if (q.good_cnt < need)
              d.good_cnt = 3'(q.good_cnt + 3'h1);
            if (3'(q.good_cnt + 3'h1) >= need)
              d.lock = 1'b1;
          end
          else
          begin
            d.good_cnt = 3'h0;
            if (eval_bad)
              d.lock = 1'b0;
          end
        end
        else
          d.abp_cnt = 3'(q.abp_cnt + 3'h1);
      end
    end

    if (q.ref_pulse)
      d.ref_tgl = ~q.ref_tgl;
    if (fb_pulse)
      d.fb_tgl = ~q.fb_tgl;

    // charge pump controls
    d.pwr_dn = pd;
    d.pump_gain = q.fb_l[pls_pkg::GAIN_BIT];
    d.pump_hiz = pd | tri_st;
    d.pump_up = ~(pd | tri_st) & (pol ? q.up : q.dn);
    d.pump_dn = ~(pd | tri_st) & (pol ? q.dn : q.up);

    // monitor multiplexer
    case (mux)
      pls_pkg::MUX_LOCK: d.mon = q.lock;
      pls_pkg::MUX_FB: d.mon = q.fb_tgl;
      pls_pkg::MUX_HIGH: d.mon = 1'b1;
      pls_pkg::MUX_REF: d.mon = q.ref_tgl;
      pls_pkg::MUX_ALOCK: d.mon = ~(q.up | q.dn);
      pls_pkg::MUX_SDO: d.mon = q.sr[pls_pkg::SR_W-1];
      default: d.mon = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= d;
  end

  assign pump_up_o = q.pump_up;
  assign pump_dn_o = q.pump_dn;
  assign pump_hiz_o = q.pump_hiz;
  assign pump_gain_o = q.pump_gain;
  assign power_down_o = q.pwr_dn;
  assign lock_detect_o = q.lock;
  assign monitor_output_o = q.mon;

  // ====================================================
  // checks
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence load_to(logic [1:0] sel);
    sy_rise[P_LE] && q.sr[1:0] == sel;
  endsequence

  sequence both_high;
    q.up && q.dn && !hold;
  endsequence

  chk_shift_msb: assert property (sy_rise[P_SCLK] |=>
    q.sr == {$past(q.sr[pls_pkg::SR_W-2:0]), $past(sy_lvl[P_DATA])})
    else $error("serial bit not shifted in at the bottom");
  chk_load_ref: assert property (load_to(pls_pkg::SEL_REF) |=>
    q.ref_l == {$past(q.sr[23:2]), 2'h0} && $stable(q.fb_l) && $stable(q.fn_l))
    else $error("reference latch load wrong");
  chk_load_fb: assert property (load_to(pls_pkg::SEL_FB) |=>
    q.fb_l == {$past(q.sr[23:2]), 2'h0} && $stable(q.ref_l))
    else $error("feedback latch load wrong");
  chk_load_init: assert property (load_to(pls_pkg::SEL_INIT) |=>
    q.init_clr ##1 q.r_cnt == 14'h0000 && !q.up && !q.dn)
    else $error("init load did not restart counters");
  chk_latch_hold: assert property (!sy_rise[P_LE] |=>
    $stable(q.ref_l) && $stable(q.fb_l) && $stable(q.fn_l))
    else $error("latch changed without load strobe");
  chk_ref_wrap: assert property (q.ref_pulse |->
    15'({1'b0, $past(q.r_cnt)} + 15'h0001) >= {1'b0, $past(r_div)} && q.r_cnt == 14'h0000)
    else $error("reference divider wrapped early");
  chk_pfd_clear: assert property (both_high |-> ##[1:5] !(q.up && q.dn))
    else $error("detector reset not released");
  chk_lock_three: assert property ($rose(q.lock) && !lock_precision_sel |->
    $past(q.good_cnt) + 3'h1 >= pls_pkg::LOCK_CNT_LO)
    else $error("lock set before three good cycles");
  chk_lock_five: assert property ($rose(q.lock) && lock_precision_sel && $stable(lock_precision_sel) |->
    $past(q.good_cnt) + 3'h1 >= pls_pkg::LOCK_CNT_HI)
    else $error("lock set before five good cycles");
  chk_unlock: assert property (eval_bad && !hold |=> !q.lock ##1 !q.lock)
    else $error("lock held after large phase error");
  chk_alock_out: assert property (mux == pls_pkg::MUX_ALOCK && !q.up && !q.dn |=> q.mon)
    else $error("analog lock low without detector activity");
  chk_pump_off: assert property (pd || tri_st |=> q.pump_hiz && !q.pump_up && !q.pump_dn)
    else $error("pump driven while off");

  // lock may fall only on a bad evaluation or a hold, never by itself
  chk_lock_hold: assert property (q.lock && !hold && !eval_bad |=>
    q.lock)
    else $error("lock dropped without large phase error");
  // a hold parks the reference counter and clears the lock indication
  chk_ref_hold: assert property (hold |=>
    q.r_cnt == 14'h0000 && !q.lock && !q.up && !q.dn)
    else $error("hold did not park counter and detector");
endmodule : pls_core

// ---- tb/pls_host_model.sv ----
/*
  pls_host_model: host controller on the three wire serial link.
  assumes the bench calls write_word and strobe at a rising ref_clk_i edge.
*/
`timescale 1ns/1ps
module pls_host_model (
  input wire logic ref_clk_i,
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic load_strobe_o
);
  // ====================================================
  // serial link driver
  initial
  begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    load_strobe_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : wait_clk

  // pins pass a 3 flop filter, so every level is held 5 clocks, the strobe 6
  task automatic strobe();
    load_strobe_o <= 1'b1;
    wait_clk(6);
    load_strobe_o <= 1'b0;
    wait_clk(6);
  endtask : strobe

  task automatic write_word(input logic [23:0] word, input logic do_load);
    for (int i = 23; i >= 0; i--)
    begin
      ser_data_o <= word[i];
      wait_clk(5);
      ser_clk_o <= 1'b1;
      wait_clk(5);
      ser_clk_o <= 1'b0;
      // hold time over: show the inverse, not a stale bit
      ser_data_o <= ~word[i];
      wait_clk(5);
    end
    if (do_load)
      strobe();
  endtask : write_word
endmodule : pls_host_model

// ---- tb/pls_core_tb_top.sv ----
/*
  pls_core_tb_top: serial loads, dividers, detector and lock seen at
  the core outputs.
  assumes the host model drives the serial pins, the bench ref and rf pins.
*/
`timescale 1ns/1ps
module pls_core_tb_top;
  logic ref_clk_i;
  logic rst_i;
  logic ser_clk;
  logic ser_data;
  logic load_strobe;
  logic ref_input_i;
  logic rf_input_i;
  logic pump_up_o;
  logic pump_dn_o;
  logic pump_hiz_o;
  logic pump_gain_o;
  logic power_down_o;
  logic lock_detect_o;
  logic monitor_output_o;
  logic [15:0] failures = 16'h0;
  logic [15:0] compares = 16'h0;
  logic [15:0] toggles = 16'h0;
  logic [15:0] t0;
  logic mon_q;
  logic [2:0] mx [4] = '{pls_pkg::MUX_ALOCK, pls_pkg::MUX_HIGH, pls_pkg::MUX_SDO, pls_pkg::MUX_SDO};
  logic [1:0] px [4] = '{2'h3, 2'h0, 2'h3, 2'h1};
  logic [12:0] bx [4] = '{13'h3, 13'h4, 13'h3, 13'h3};
  logic [5:0] ax [4] = '{6'h2, 6'h3, 6'h0, 6'h1};

  pls_core pls_core_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ser_clk_i(ser_clk), .ser_data_i(ser_data),
    .load_strobe_i(load_strobe), .ref_input_i(ref_input_i), .rf_input_i(rf_input_i),
    .pump_up_o(pump_up_o), .pump_dn_o(pump_dn_o), .pump_hiz_o(pump_hiz_o), .pump_gain_o(pump_gain_o),
    .power_down_o(power_down_o), .lock_detect_o(lock_detect_o), .monitor_output_o(monitor_output_o));
  pls_host_model pls_host_model_i (.ref_clk_i(ref_clk_i), .ser_clk_o(ser_clk), .ser_data_o(ser_data),
    .load_strobe_o(load_strobe));

  // ====================================================
  // clock, toggle counter, helpers
  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  // scaled outputs are judged by counting their changes
  always @(posedge ref_clk_i)
  begin
    mon_q <= monitor_output_o;
    if (monitor_output_o !== mon_q)
      toggles <= toggles + 16'h1;
  end

  function automatic logic [23:0] ref_w(input logic [13:0] r, input logic lock_precision_sel);
    return {3'h0, lock_precision_sel, 4'h0, r, pls_pkg::SEL_REF};
  endfunction : ref_w

  function automatic logic [23:0] fb_w(input logic gain, input logic [12:0] b, input logic [5:0] a);
    return {2'h0, gain, b, a, pls_pkg::SEL_FB};
  endfunction : fb_w

  function automatic logic [23:0] fn_w(input logic [1:0] pre, input logic hiz, input logic pol,
    input logic [2:0] mux, input logic pd, input logic [1:0] sel);
    return {pre, 12'h0, hiz, pol, 1'h0, mux, pd, 1'h0, sel};
  endfunction : fn_w

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : wait_clk

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares = compares + 16'h1;
    if (seen !== exp)
    begin
      failures = failures + 16'h1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_end(input string name);
    $display("test %s done, failures so far %0d", name, failures);
  endtask : test_end

  task automatic setup(input logic [23:0] rw, input logic [23:0] fw, input logic [23:0] iw);
    pls_host_model_i.write_word(rw, 1'b1);
    pls_host_model_i.write_word(fw, 1'b1);
    pls_host_model_i.write_word(iw, 1'b1);
  endtask : setup

  // slow pin edges keep the prescaled rate far below its ceiling
  task automatic pulse(input logic on_ref, input logic on_rf, input int n);
    repeat (n)
    begin
      ref_input_i <= on_ref;
      rf_input_i <= on_rf;
      wait_clk(5);
      ref_input_i <= 1'b0;
      rf_input_i <= 1'b0;
      wait_clk(5);
    end
    wait_clk(4);
  endtask : pulse

  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 16'h0 && compares != 16'h0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // ====================================================
  // tests
  initial
  begin
    rst_i = 1'b1;
    ref_input_i = 1'b0;
    rf_input_i = 1'b0;
    wait_clk(3);
    rst_i <= 1'b0;
    wait_clk(2);
    check(16'({pump_up_o, pump_dn_o, pump_hiz_o, pump_gain_o, power_down_o, lock_detect_o,
      monitor_output_o}), 16'h0);
    test_end("reset");
    // bit 21 set under every select: only the feedback latch takes it as gain
    for (int s = 0; s < 4; s++)
    begin
      pls_host_model_i.write_word(24'h20_0000 | 24'(2'(s + 2)), 1'b1);
      check(16'(pump_gain_o), 16'(s == 3));
    end
    pls_host_model_i.write_word(fb_w(1'b0, 13'h3, 6'h0), 1'b0);
    check(16'(pump_gain_o), 16'h1);
    pls_host_model_i.strobe();
    check(16'(pump_gain_o), 16'h0);
    test_end("latch select");
    pls_host_model_i.write_word(fn_w(2'h0, 1'b0, 1'b1, pls_pkg::MUX_LOW, 1'b1, pls_pkg::SEL_FUNC), 1'b1);
    check(16'({power_down_o, pump_hiz_o}), 16'h3);
    pls_host_model_i.write_word(fn_w(2'h0, 1'b1, 1'b1, pls_pkg::MUX_LOW, 1'b0, pls_pkg::SEL_FUNC), 1'b1);
    check(16'({power_down_o, pump_hiz_o}), 16'h1);
    for (int m = 0; m < 4; m++)
    begin
      pls_host_model_i.write_word(fn_w(px[m], 1'b0, 1'b1, mx[m], 1'b0, pls_pkg::SEL_FUNC), 1'b1);
      wait_clk(2);
      check(16'(monitor_output_o), 16'((mx[m] == pls_pkg::MUX_HIGH) | (mx[m] == pls_pkg::MUX_ALOCK) |
        (mx[m] == pls_pkg::MUX_SDO & px[m][1])));
    end
    test_end("function latch");
    setup(ref_w(14'h1, 1'b0), fb_w(1'b0, 13'h3, 6'h0),
      fn_w(2'h0, 1'b0, 1'b1, pls_pkg::MUX_LOW, 1'b0, pls_pkg::SEL_INIT));
    pulse(1'b1, 1'b0, 1);
    check(16'({pump_up_o, pump_dn_o}), 16'h2);
    pls_host_model_i.write_word(fn_w(2'h0, 1'b0, 1'b0, pls_pkg::MUX_LOW, 1'b0, pls_pkg::SEL_FUNC), 1'b1);
    check(16'({pump_up_o, pump_dn_o}), 16'h1);
    test_end("detector");
    for (int r = 1; r < 8; r += 3)
    begin
      setup(ref_w(14'(r), 1'b0), fb_w(1'b0, 13'h3, 6'h0),
        fn_w(2'h0, 1'b0, 1'b1, pls_pkg::MUX_REF, 1'b0, pls_pkg::SEL_INIT));
      t0 = toggles;
      pulse(1'b1, 1'b0, 2 * r);
      check(toggles - t0, 16'h2);
    end
    test_end("reference divider");
    // main count kept at 3 or more and not below the swallow value
    for (int p = 0; p < 4; p++)
    begin
      setup(ref_w(14'h1, 1'b0), fb_w(1'b0, bx[p], ax[p]),
        fn_w(2'(p), 1'b0, 1'b1, pls_pkg::MUX_FB, 1'b0, pls_pkg::SEL_INIT));
      t0 = toggles;
      pulse(1'b0, 1'b1, 2 * ((8 << p) * bx[p] + ax[p]));
      check(toggles - t0, 16'h2);
    end
    test_end("feedback divider");
    // ref and rf share one waveform; ratio 24 on both keeps them in phase
    for (int l = 0; l < 2; l++)
    begin
      setup(ref_w(14'h18, 1'(l)), fb_w(1'b0, 13'h3, 6'h0),
        fn_w(2'h0, 1'b0, 1'b1, pls_pkg::MUX_LOCK, 1'b0, pls_pkg::SEL_INIT));
      pulse(1'b1, 1'b1, 24 * (2 + 2 * l) + 12);
      check(16'(lock_detect_o), 16'h0);
      pulse(1'b1, 1'b1, 24);
      check(16'({lock_detect_o, monitor_output_o}), 16'h3);
      pulse(1'b0, 1'b1, 1);
      pulse(1'b1, 1'b1, 36);
      check(16'(lock_detect_o), 16'h0);
    end
    test_end("lock detect");
    test_done();
  end

  initial
  begin
    wait_clk(60000);
    failures = failures + 16'h1;
    test_done();
  end
endmodule : pls_core_tb_top
